// ==== rtl/deadband_gen.sv ====
// module: complementary output pair with a deadband gap on each pwm transition, rising or falling
// assumes one count tick enables the deadband timer
module deadband_gen (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       tick,
	input  wire logic       pwm_in,
	input  wire logic [7:0] dead_len,
	output logic            out_hi,
	output logic            out_lo
);
	// ============================================================
	// deadband timer
	logic       prev;   // last pwm level
	logic [7:0] dcnt;   // remaining gap ticks
	wire        edge_seen = pwm_in ^ prev;
	wire        in_gap    = edge_seen | (dcnt != 8'h00);

	// gap counter restarts on each pwm transition
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prev   <= 1'b0;
			dcnt   <= 8'h00;
			out_hi <= 1'b0;
			out_lo <= 1'b0;
		end else begin
			prev <= pwm_in;
			if (edge_seen)
				dcnt <= dead_len;
			else if (tick && dcnt != 8'h00)
				dcnt <= dcnt - 8'h01;
			// neither output active during the gap
			out_hi <= pwm_in & ~in_gap;
			out_lo <= ~pwm_in & ~in_gap;
		end
	end
endmodule

// ==== rtl/tick_select.sv ====
// module: counter clock source selection, producing a one-cycle count tick
// assumes external clock input is already synchronised to mclk
module tick_select (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [1:0] clk_sel,
	input  wire logic       ext_clk_sync,
	output logic            tick
);
	// ============================================================
	// prescaler and edge detect
	logic [15:0] div_cnt;      // free-running divider
	logic        ext_prev;     // last external level
	wire         div_hit  = (div_cnt == tcpwm_pkg::prescale_div - 16'h0001);
	wire         ext_rise = ext_clk_sync & ~ext_prev;

	// divider and edge history
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_cnt  <= 16'h0000;
			ext_prev <= 1'b0;
		end else begin
			div_cnt  <= div_hit ? 16'h0000 : div_cnt + 16'h0001;
			ext_prev <= ext_clk_sync;
		end
	end

	// source select: 0 mclk, 1 mclk/2, 2 prescaled, 3 external rising edge
	always_comb begin
		case (clk_sel)
			2'd0:    tick = 1'b1;
			2'd1:    tick = div_cnt[0];
			2'd2:    tick = div_hit;
			default: tick = ext_rise;
		endcase
	end
endmodule

// ==== rtl/timer_counter_pwm_unit.sv ====
// top: 16-bit down-counting timer, counter and pwm with capture and kill
// assumes capture, enable, reset, kill and external clock come from outside mclk
// Function
// - sixteen-bit counter that only counts down
// - counter clock chosen among several sources
// - reload period on start, reset, terminal count
// - compare count with selectable relation
// - compare and terminal count outputs, optional complement
// - free run, one shot or enable mode
// - one shot stops at period end
// - enable mode counts only while enabled
// - capture input stores full count
// - kill forces compare outputs inactive
// - complementary pwm pair with deadband gap
// - interrupt on terminal count, compare, capture
//
// Decided for this implementation: the register addresses and the strobed register port.
module timer_counter_pwm_unit (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        ext_clk,
	input  wire logic        count_en,
	input  wire logic        timer_rst,
	input  wire logic        capture_in,
	input  wire logic        kill,
	output logic             cmp_out,
	output logic             tc_out,
	output logic             pwm_hi,
	output logic             pwm_lo,
	output logic             irq
);
	// ============================================================
	// input synchronisers: three stages, change taken when stages 2 and 3 agree
	logic [2:0] s_ext, s_en, s_rst, s_cap, s_kill;  // shift chains
	logic       ext_q, en_q, rst_q, cap_q, kill_q;  // filtered levels

	// synchroniser chains and agreement filters
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_ext  <= 3'b000;
			s_en   <= 3'b000;
			s_rst  <= 3'b000;
			s_cap  <= 3'b000;
			s_kill <= 3'b000;
			ext_q  <= 1'b0;
			en_q   <= 1'b0;
			rst_q  <= 1'b0;
			cap_q  <= 1'b0;
			kill_q <= 1'b0;
		end else begin
			s_ext  <= {s_ext[1:0], ext_clk};
			s_en   <= {s_en[1:0], count_en};
			s_rst  <= {s_rst[1:0], timer_rst};
			s_cap  <= {s_cap[1:0], capture_in};
			s_kill <= {s_kill[1:0], kill};
			if (s_ext[1] == s_ext[2])
				ext_q <= s_ext[2];
			if (s_en[1] == s_en[2])
				en_q <= s_en[2];
			if (s_rst[1] == s_rst[2])
				rst_q <= s_rst[2];
			if (s_cap[1] == s_cap[2])
				cap_q <= s_cap[2];
			if (s_kill[1] == s_kill[2])
				kill_q <= s_kill[2];
		end
	end

	// ============================================================
	// registers
	logic [31:0] ctrl;       // control word
	logic [15:0] period;     // reload value
	logic [15:0] compare;    // compare value
	logic [15:0] count;      // live counter
	logic [15:0] capture;    // captured count
	logic [7:0]  dead_len;   // deadband in counter ticks
	logic [2:0]  status;     // sticky tc, compare, capture events
	logic        running;    // counter active
	logic        run_prev;   // last run bit, for start edge
	logic        cap_prev;   // last capture level

	// field decodes
	wire [1:0] mode    = ctrl[tcpwm_pkg::ctrl_mode_lo +: 2];
	wire [2:0] rel     = ctrl[tcpwm_pkg::ctrl_cmp_lo +: 3];
	wire [1:0] clk_sel = ctrl[tcpwm_pkg::ctrl_clk_lo +: 2];
	wire [2:0] irq_en  = ctrl[tcpwm_pkg::ctrl_irq_lo +: 3];
	wire       compl   = ctrl[tcpwm_pkg::ctrl_compl_bit];
	wire       run_bit = ctrl[tcpwm_pkg::ctrl_run_bit];

	// write decodes
	wire wr_ctrl   = wr && addr == tcpwm_pkg::off_ctrl;
	wire wr_period = wr && addr == tcpwm_pkg::off_period;
	wire wr_cmp    = wr && addr == tcpwm_pkg::off_compare;
	wire wr_dead   = wr && addr == tcpwm_pkg::off_deadband;
	wire wr_status = wr && addr == tcpwm_pkg::off_status;

	// ============================================================
	// counter clock
	logic tick;  // one-cycle count enable from chosen source
	tick_select tick_select_inst (
		.mclk         (mclk),
		.nrst         (nrst),
		.clk_sel      (clk_sel),
		.ext_clk_sync (ext_q),
		.tick         (tick)
	);

	// ============================================================
	// counter control
	wire start     = run_bit & ~run_prev;
	wire at_tc     = (count == 16'h0000);
	wire gate_ok   = (mode != tcpwm_pkg::mode_enable) | en_q;
	wire step      = running & tick & gate_ok;
	wire tc_evt    = step & at_tc;
	wire cap_evt   = cap_q & ~cap_prev;
	// one shot stops after its terminal count
	wire stop_evt  = tc_evt & (mode == tcpwm_pkg::mode_oneshot);

	logic cmp_raw;  // relation result
	always_comb begin
		case (tcpwm_pkg::cmp_rel_t'(rel))
			tcpwm_pkg::less_than:        cmp_raw = count < compare;
			tcpwm_pkg::less_or_equal:    cmp_raw = count <= compare;
			tcpwm_pkg::equal_to:         cmp_raw = count == compare;
			tcpwm_pkg::greater_or_equal: cmp_raw = count >= compare;
			tcpwm_pkg::greater_than:     cmp_raw = count > compare;
			default:                     cmp_raw = 1'b0;
		endcase
	end

	wire cmp_live = cmp_raw & ~kill_q;
	wire [2:0] evts = {cap_evt, cmp_live & step, tc_evt};

	// control registers written by software
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl     <= tcpwm_pkg::ctrl_reset;
			period   <= tcpwm_pkg::period_reset;
			compare  <= tcpwm_pkg::compare_reset;
			dead_len <= tcpwm_pkg::deadband_reset;
			run_prev <= 1'b0;
		end else begin
			run_prev <= run_bit;
			if (wr_ctrl)
				ctrl <= wdata;
			if (wr_period)
				period <= wdata[15:0];
			if (wr_cmp)
				compare <= wdata[15:0];
			if (wr_dead)
				dead_len <= wdata[7:0];
		end
	end

	// counter, run flag and capture
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			count    <= 16'h0000;
			running  <= 1'b0;
			capture  <= 16'h0000;
			cap_prev <= 1'b0;
		end else begin
			cap_prev <= cap_q;
			if (start || rst_q)
				count <= period;
			else if (tc_evt)
				count <= period;
			else if (step)
				count <= count - 16'h0001;
			if (!run_bit)
				running <= 1'b0;
			else if (start)
				running <= 1'b1;
			else if (stop_evt)
				running <= 1'b0;
			if (cap_evt)
				capture <= count;
		end
	end

	// sticky events, set wins over write-one clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			status <= 3'b000;
		else
			status <= evts | (status & ~(wr_status ? wdata[2:0] : 3'b000));
	end

	// ============================================================
	// outputs
	// compare and terminal count outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cmp_out <= 1'b0;
			tc_out  <= 1'b0;
			irq     <= 1'b0;
		end else begin
			cmp_out <= cmp_live;
			// complementary compare replaces tc when selected
			tc_out  <= compl ? (~cmp_raw & ~kill_q) : (running & at_tc);
			irq     <= |(status & irq_en);
		end
	end

	deadband_gen deadband_gen_inst (
		.mclk     (mclk),
		.nrst     (nrst),
		.tick     (tick),
		.pwm_in   (cmp_live),
		.dead_len (dead_len),
		.out_hi   (pwm_hi),
		.out_lo   (pwm_lo)
	);

	// ============================================================
	// read path: data the cycle after the read strobe, zero elsewhere
	logic [31:0] rd_mux;  // selected word
	always_comb begin
		case (addr)
			tcpwm_pkg::off_ctrl:     rd_mux = ctrl;
			tcpwm_pkg::off_period:   rd_mux = {16'h0000, period};
			tcpwm_pkg::off_compare:  rd_mux = {16'h0000, compare};
			tcpwm_pkg::off_count:    rd_mux = {16'h0000, count};
			tcpwm_pkg::off_capture:  rd_mux = {16'h0000, capture};
			tcpwm_pkg::off_deadband: rd_mux = {24'h00_0000, dead_len};
			tcpwm_pkg::off_status:   rd_mux = {28'h000_0000, running, status};
			default:                 rd_mux = 32'h0000_0000;
		endcase
	end

	// read data register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			rdata <= 32'h0000_0000;
		else
			rdata <= rd ? rd_mux : 32'h0000_0000;
	end

	// ============================================================
	// checks
	property p_reload_tc;
		@(posedge mclk) disable iff (!nrst)
		(tc_evt && !start && !rst_q) |=> count == $past(period);
	endproperty
	a_reload_tc: assert property (p_reload_tc) else $error("no reload at tc");
	property p_down;
		@(posedge mclk) disable iff (!nrst)
		(step && !at_tc && !start && !rst_q) |=> count == $past(count) - 16'h0001;
	endproperty
	a_down: assert property (p_down) else $error("count not decremented");
	property p_hold;
		@(posedge mclk) disable iff (!nrst)
		(mode == tcpwm_pkg::mode_enable && !en_q && !start && !rst_q) |=> count == $past(count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while disabled");
	property p_oneshot;
		@(posedge mclk) disable iff (!nrst)
		(stop_evt && !start) |=> !running;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one shot kept running");
	property p_capture;
		@(posedge mclk) disable iff (!nrst)
		cap_evt |=> capture == $past(count);
	endproperty
	a_capture: assert property (p_capture) else $error("capture wrong");
	property p_kill;
		@(posedge mclk) disable iff (!nrst)
		kill_q |=> !cmp_out;
	endproperty
	a_kill: assert property (p_kill) else $error("compare active under kill");
	property p_dead;
		@(posedge mclk) disable iff (!nrst)
		!(pwm_hi && pwm_lo);
	endproperty
	a_dead: assert property (p_dead) else $error("both pwm outputs active");
	property p_irq;
		@(posedge mclk) disable iff (!nrst)
		(tc_evt && irq_en[0] && !(wr_ctrl)) |=> ##1 irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no irq on tc");
endmodule

// ==== shared/tcpwm_pkg.sv ====
// package: register map, field positions, reset values and modes of the timer unit
// assumes a plain register port with one-cycle strobes and 32-bit words
package tcpwm_pkg;
	// ============================================================
	// register offsets (byte addresses)
	localparam logic [7:0] off_ctrl     = 8'h00;
	localparam logic [7:0] off_period   = 8'h04;
	localparam logic [7:0] off_compare  = 8'h08;
	localparam logic [7:0] off_count    = 8'h0C;
	localparam logic [7:0] off_capture  = 8'h10;
	localparam logic [7:0] off_deadband = 8'h14;
	localparam logic [7:0] off_status   = 8'h18;
	// ============================================================
	// control register fields
	localparam int ctrl_run_bit   = 0;   // start counting
	localparam int ctrl_mode_lo   = 1;   // run mode, two bits
	localparam int ctrl_cmp_lo    = 3;   // compare relation, three bits
	localparam int ctrl_clk_lo    = 6;   // clock source, two bits
	localparam int ctrl_irq_lo    = 8;   // interrupt source enables, three bits
	localparam int ctrl_compl_bit = 11;  // complementary output select
	localparam logic [31:0] ctrl_reset      = 32'h0000_0000;
	localparam logic [15:0] period_reset    = 16'hFFFF;
	localparam logic [15:0] compare_reset   = 16'h0000;
	localparam logic [7:0]  deadband_reset  = 8'h00;
	localparam logic [15:0] prescale_div    = 16'h0008; // divider for source 2
	// ============================================================
	// enumerations
	typedef enum logic [1:0] {
		mode_free    = 2'b00,
		mode_oneshot = 2'b01,
		mode_enable  = 2'b11
	} run_mode_t;
	typedef enum logic [2:0] {
		less_than        = 3'b000,
		less_or_equal    = 3'b001,
		equal_to         = 3'b010,
		greater_or_equal = 3'b011,
		greater_than     = 3'b100
	} cmp_rel_t;
endpackage

// ==== tb/far_side_model.sv ====
// model: routing fabric side that drives the timer's control inputs
// assumes the bench calls its tasks from the mclk domain
module far_side_model (
	input  wire logic mclk,
	output logic      ext_clk,
	output logic      count_en,
	output logic      timer_rst,
	output logic      capture_in,
	output logic      kill
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ext_on;  // external source running
	int   ext_div; // mclk edges since the last external toggle

	// ============================================================
	// idle levels
	initial begin
		{ext_clk, count_en, timer_rst, capture_in, kill, ext_on} = 6'b00_0000;
		ext_div = 0;
	end

	// ============================================================
	// external source, 20 mclk period, still while off; moves just after a rising edge
	always @(posedge mclk) begin
		if (ext_on) begin
			ext_div <= (ext_div == 9) ? 0 : ext_div + 1;
			if (ext_div == 9) begin
				ext_clk <= ~ext_clk;
			end
		end
	end

	// level inputs change just after an edge
	task automatic levels(input logic en, input logic rst, input logic kl, input logic ext);
		@(posedge mclk);
		count_en  <= en;
		timer_rst <= rst;
		kill      <= kl;
		ext_on    <= ext;
	endtask

	// capture pulse, wide enough to pass the input filter
	task automatic pulse_capture();
		@(posedge mclk);
		capture_in <= 1'b1;
		repeat (6) @(posedge mclk);
		capture_in <= 1'b0;
	endtask
endmodule

// ==== tb/timer_counter_pwm_unit_tb_top.sv ====
// bench: scenario tasks on the register port and the fabric-side model
// assumes 50 MHz mclk and async inputs settling within 8 cycles
module timer_counter_pwm_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, nrst, wr, rd;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, v0, v1;
	logic        ext_clk, count_en, timer_rst, capture_in, kill;
	logic        cmp_out, tc_out, pwm_hi, pwm_lo, irq;
	int          err_total, checks, low_run, min_gap;
	logic        seen_hi, seen_lo; // pwm activity flags

	always #10 mclk = ~mclk;

	timer_counter_pwm_unit timer_counter_pwm_unit_inst (.mclk(mclk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_clk(ext_clk), .count_en(count_en),
		.timer_rst(timer_rst), .capture_in(capture_in), .kill(kill), .cmp_out(cmp_out),
		.tc_out(tc_out), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo), .irq(irq));
	far_side_model far_side_model_inst (.mclk(mclk), .ext_clk(ext_clk), .count_en(count_en),
		.timer_rst(timer_rst), .capture_in(capture_in), .kill(kill));

	// ============================================================
	// bus cycles and compares
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// read data valid only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		chk_word({31'h0000_0000, got}, {31'h0000_0000, exp}, m);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// ============================================================
	// scenarios
	task automatic t_reset();
		rd_reg(tcpwm_pkg::off_ctrl, v0);
		chk_word(v0, tcpwm_pkg::ctrl_reset, "ctrl reset");
		rd_reg(tcpwm_pkg::off_period, v0);
		chk_word(v0, {16'h0000, tcpwm_pkg::period_reset}, "period reset");
		rd_reg(8'h1C, v0);
		chk_word(v0, 32'h0000_0000, "unmapped read");
	endtask
	// sources 0..2: ticks seen between two reads 2 cycles apart, 8 for source 2
	task automatic t_sources();
		wr_reg(tcpwm_pkg::off_period, 32'h0000_03E8);
		for (int s = 0; s < 3; s++) begin
			wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
			wr_reg(tcpwm_pkg::off_ctrl, 32'(1 | (s << 6)));
			rd_reg(tcpwm_pkg::off_count, v0);
			cyc(s == 2 ? 6 : 0);
			rd_reg(tcpwm_pkg::off_count, v1);
			chk_word(v0 - v1, (s == 0) ? 32'h0000_0002 : 32'h0000_0001, "step");
			chk_bit(v0 <= 32'h0000_03E8 && v0 > 32'h0000_03D0, 1'b1, "start load");
		end
		// external source counts two edges in 40 cycles
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_00C1);
		far_side_model_inst.levels(1'b0, 1'b0, 1'b0, 1'b1);
		rd_reg(tcpwm_pkg::off_count, v0);
		cyc(38);
		rd_reg(tcpwm_pkg::off_count, v1);
		chk_word(v0 - v1, 32'h0000_0002, "ext step");
		far_side_model_inst.levels(1'b0, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_oneshot();
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
		wr_reg(tcpwm_pkg::off_status, 32'h0000_0007);
		wr_reg(tcpwm_pkg::off_period, 32'h0000_000A);
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0003);
		cyc(40);
		rd_reg(tcpwm_pkg::off_status, v0);
		chk_bit(v0[3], 1'b0, "oneshot running");
		chk_bit(v0[0], 1'b1, "oneshot tc");
		rd_reg(tcpwm_pkg::off_count, v1);
		cyc(10);
		rd_reg(tcpwm_pkg::off_count, v0);
		chk_word(v0, v1, "oneshot held");
	endtask
	task automatic t_enable();
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
		wr_reg(tcpwm_pkg::off_period, 32'h0000_03E8);
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0007);
		cyc(8);
		rd_reg(tcpwm_pkg::off_count, v0);
		cyc(20);
		rd_reg(tcpwm_pkg::off_count, v1);
		chk_word(v1, v0, "held without enable");
		far_side_model_inst.levels(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(8);
		rd_reg(tcpwm_pkg::off_count, v0);
		rd_reg(tcpwm_pkg::off_count, v1);
		chk_word(v0 - v1, 32'h0000_0002, "count with enable");
		far_side_model_inst.levels(1'b0, 1'b0, 1'b0, 1'b0);
		// zero period parks a stalled running count on terminal count
		wr_reg(tcpwm_pkg::off_period, 32'h0000_0000);
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0007);
		cyc(3);
		chk_bit(tc_out, 1'b1, "tc level");
	endtask
	// stopped count reloaded to abcd, then capture, relations, kill
	task automatic t_cap_cmp();
		logic e;
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
		wr_reg(tcpwm_pkg::off_period, 32'h0000_ABCD);
		far_side_model_inst.levels(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(8);
		far_side_model_inst.levels(1'b0, 1'b0, 1'b0, 1'b0);
		rd_reg(tcpwm_pkg::off_count, v0);
		chk_word(v0, 32'h0000_ABCD, "reset reload");
		far_side_model_inst.pulse_capture();
		cyc(8);
		rd_reg(tcpwm_pkg::off_capture, v0);
		chk_word(v0, 32'h0000_ABCD, "capture");
		for (int r = 0; r < 5; r++) begin
			for (int d = -1; d < 2; d++) begin
				wr_reg(tcpwm_pkg::off_compare, 32'(32'h0000_ABCD + d));
				wr_reg(tcpwm_pkg::off_ctrl, 32'(r << 3));
				cyc(3);
				e = (r == 0) ? d > 0 : (r == 1) ? d >= 0 : (r == 2) ? d == 0 : (r == 3) ? d <= 0 : d < 0;
				chk_bit(cmp_out, e, "relation");
			end
		end
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0810);
		cyc(3);
		chk_bit(tc_out, 1'b1, "complement");
		// less-than holds now, so kill has an active compare to override
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0800);
		cyc(3);
		chk_bit(tc_out, 1'b0, "complement low");
		chk_bit(cmp_out, 1'b1, "compare before kill");
		far_side_model_inst.levels(1'b0, 1'b0, 1'b1, 1'b0);
		cyc(8);
		chk_bit(cmp_out, 1'b0, "kill");
		far_side_model_inst.levels(1'b0, 1'b0, 1'b0, 1'b0);
	endtask
	// sources: terminal count, compare, capture; raise, mask, clear
	task automatic t_irq();
		wr_reg(tcpwm_pkg::off_period, 32'h0000_0003);
		wr_reg(tcpwm_pkg::off_compare, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
			wr_reg(tcpwm_pkg::off_status, 32'h0000_0007);
			wr_reg(tcpwm_pkg::off_ctrl, 32'((i < 2) | (3 << 3) | (1 << (8 + i))));
			if (i == 2) begin
				far_side_model_inst.pulse_capture();
			end
			cyc(12);
			chk_bit(irq, 1'b1, "irq raised");
			wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
			cyc(3);
			chk_bit(irq, 1'b0, "irq masked");
			wr_reg(tcpwm_pkg::off_status, 32'h0000_0007);
			wr_reg(tcpwm_pkg::off_ctrl, 32'(1 << (8 + i)));
			cyc(3);
			chk_bit(irq, 1'b0, "irq cleared");
		end
	endtask
	task automatic t_deadband();
		wr_reg(tcpwm_pkg::off_deadband, 32'h0000_0004);
		wr_reg(tcpwm_pkg::off_period, 32'h0000_0014);
		wr_reg(tcpwm_pkg::off_compare, 32'h0000_000A);
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0001);
		cyc(4);
		// clear the monitor away from its edge so its updates cannot race this
		@(negedge mclk);
		{seen_hi, seen_lo, min_gap} = {2'b00, 32'd1000};
		cyc(200);
		chk_bit(seen_hi && seen_lo, 1'b1, "pair toggles");
		chk_bit(min_gap >= 4, 1'b1, "gap length");
		wr_reg(tcpwm_pkg::off_ctrl, 32'h0000_0000);
	endtask

	// ============================================================
	// pair monitor: never both high, shortest gap before a rise
	always @(posedge mclk) begin
		if (pwm_hi === 1'b1 && pwm_lo === 1'b1) begin
			err_total++;
			$display("CHECK FAILED t=%0t pwm pair overlap", $time);
		end
		seen_hi <= seen_hi | (pwm_hi === 1'b1);
		seen_lo <= seen_lo | (pwm_lo === 1'b1);
		low_run <= (pwm_hi | pwm_lo) ? 0 : low_run + 1;
		if ((pwm_hi | pwm_lo) && low_run > 0 && low_run < min_gap) begin
			min_gap <= low_run;
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// main sequence after an 8-cycle reset
	initial begin
		{mclk, nrst, wr, rd, addr, wdata} = '0;
		{err_total, checks, low_run, min_gap, seen_hi, seen_lo} = '0;
		cyc(8);
		nrst <= 1'b1;
		t_reset();
		t_sources();
		t_oneshot();
		t_enable();
		t_cap_cmp();
		t_irq();
		t_deadband();
		test_done();
	end
	// watchdog, far beyond the expected seven hundred or so cycles
	initial begin
		#300_000;
		err_total++;
		test_done();
	end
endmodule
